/* crps_pkg.sv */
// Purpose: shared constants for the reset and park sequencing ends
// Assumes: 40 MHz system clock
// Notes: times kept in their own units, cycle counts derived
package crps_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int PARK_WINDOW_US = 500;
    localparam int INIT_MIN_MS = 100;
    localparam int GLITCH_NS = 150;
    localparam int HOST_TIMER_MS = 100;
    localparam int PARK_HIGH_DELAY_US = 10;
    // least times round up, longest round down
    localparam int INIT_MIN_CYC =
        (INIT_MIN_MS * 1000000 + CLK_PERIOD_PS / 1000 - 1) /
        (CLK_PERIOD_PS / 1000);
    localparam int HOST_TIMER_CYC =
        (HOST_TIMER_MS * 1000000) / (CLK_PERIOD_PS / 1000);
    localparam int PARK_MAX_CYC =
        (PARK_WINDOW_US * 1000000) / CLK_PERIOD_PS;
    localparam int PARK_WAIT_CYC =
        (PARK_WINDOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PARK_HIGH_CYC =
        (PARK_HIGH_DELAY_US * 1000000) / CLK_PERIOD_PS;
    localparam int GLITCH_CYC =
        (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int LOCK_CYC = 64;
    localparam int CFG_CYC = 256;
    localparam int PARK_OP_CYC = 1024;
    localparam int SPI_DIV_CYC = 2;
    localparam logic [3:0] LED_SEL_RESET = 4'h0;
endpackage : crps_pkg

/* crps_if.sv */
// Purpose: pins between the controller and its host or power monitor
// Assumes: one shared clock
// Notes: controller pin outputs carry an enable; the enable is not applied to the wire level here
`timescale 1ns/100ps
`default_nettype none
interface crps_if;
    logic resetn_pin;
    logic park_pin;
    logic init_busy_pin;
    logic init_busy_oe;
    logic mirror_array_power_enable;
    logic mirror_array_power_enable_oe;
    modport ctrl (
        input resetn_pin,
        input park_pin,
        output init_busy_pin,
        output init_busy_oe,
        output mirror_array_power_enable,
        output mirror_array_power_enable_oe
    );
    modport host (
        output resetn_pin,
        output park_pin,
        input init_busy_pin,
        input init_busy_oe,
        input mirror_array_power_enable,
        input mirror_array_power_enable_oe
    );
endinterface : crps_if
`default_nettype wire

/* crps_ctrl.sv */
// Purpose: controller end of reset release, init and park sequencing
// Assumes: link pins come from another party, so they are synchronised
// Notes: host pins resetn and park arrive over the interface
`timescale 1ns/100ps
`default_nettype none
module crps_ctrl import crps_pkg::*; #(
    parameter int INIT_CYC = INIT_MIN_CYC,
    parameter int PARK_CYC = PARK_OP_CYC,
    parameter int LOCK_CYCLES = LOCK_CYC,
    parameter int CFG_CYCLES = CFG_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    crps_if.ctrl link,
    input wire logic pll_locked,
    input wire logic flash_serial_in,
    output logic cfg_loaded,
    output logic ready_for_commands,
    output logic parked,
    output logic led_driver_on,
    output logic led_driver_on_oe,
    output logic [1:0] led_select,
    output logic [1:0] led_select_oe,
    output logic flash_serial_clock,
    output logic flash_serial_out,
    output logic flash_chip_select_n,
    output logic flash_io_oe
);
    initial begin
        if (INIT_CYC < LOCK_CYCLES + CFG_CYCLES + 1)
            $error("init time too short for lock and load");
        if (PARK_CYC < 1 || PARK_CYC > PARK_MAX_CYC)
            $error("park time outside 1..limit");
        if (PARK_CYC > INIT_CYC)
            $error("park time wider than step counter");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg, rst_sync_next;
    logic [1:0] park_sync_reg, park_sync_next;
    logic pin_rst_n;
    always_comb begin
        rst_sync_next = {rst_sync_reg[0], link.resetn_pin};
        park_sync_next = {park_sync_reg[0], link.park_pin};
    end
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rst_sync_reg <= 2'h0;
            park_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= rst_sync_next;
            park_sync_reg <= park_sync_next;
        end
    end
    assign pin_rst_n = rst_sync_reg[1] & resetn;

    // ------------------------------------------------------------
    // park filter
    // ------------------------------------------------------------
    localparam int FW = $clog2(GLITCH_CYC + 1);
    logic park_filt_reg, park_filt_next;
    logic [FW-1:0] filt_cnt_reg, filt_cnt_next;
    always_comb begin
        park_filt_next = park_filt_reg;
        filt_cnt_next = '0;
        if (park_sync_reg[1] != park_filt_reg) begin
            filt_cnt_next = filt_cnt_reg + FW'(1);
            if (filt_cnt_reg == FW'(GLITCH_CYC - 1)) begin
                park_filt_next = park_sync_reg[1];
                filt_cnt_next = '0;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!pin_rst_n) begin
            park_filt_reg <= 1'b0;
            filt_cnt_reg <= '0;
        end else begin
            park_filt_reg <= park_filt_next;
            filt_cnt_reg <= filt_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_LOCK = 6'h01,
        ST_CFG = 6'h02,
        ST_WAIT = 6'h04,
        ST_RUN = 6'h08,
        ST_PARK = 6'h10,
        ST_OFF = 6'h20
    } crps_state_t;
    localparam int CW = $clog2(INIT_CYC + 1);
    crps_state_t state_reg, state_next;
    logic [CW-1:0] init_cnt_reg, init_cnt_next;
    logic [CW-1:0] step_cnt_reg, step_cnt_next;
    logic active_reg, active_next;
    always_comb begin
        state_next = state_reg;
        init_cnt_next = init_cnt_reg;
        step_cnt_next = step_cnt_reg;
        active_next = 1'b1;
        if (init_cnt_reg != CW'(INIT_CYC))
            init_cnt_next = init_cnt_reg + CW'(1);
        unique case (state_reg)
            ST_LOCK: begin
                if (pll_locked && step_cnt_reg >= CW'(LOCK_CYCLES)) begin
                    state_next = ST_CFG;
                    step_cnt_next = '0;
                end else begin
                    step_cnt_next = step_cnt_reg + CW'(1);
                end
            end
            ST_CFG: begin
                step_cnt_next = step_cnt_reg + CW'(1);
                if (step_cnt_reg == CW'(CFG_CYCLES - 1))
                    state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (init_cnt_reg == CW'(INIT_CYC))
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if (!park_filt_reg && park_sync_reg[1] == 1'b0 &&
                        init_cnt_reg == CW'(INIT_CYC) && step_cnt_reg != '0) begin
                    state_next = ST_PARK;
                    step_cnt_next = '0;
                end else if (park_filt_reg) begin
                    step_cnt_next = CW'(1);
                end
            end
            ST_PARK: begin
                step_cnt_next = step_cnt_reg + CW'(1);
                if (step_cnt_reg == CW'(PARK_CYC - 1))
                    state_next = ST_OFF;
            end
            ST_OFF: begin
                state_next = ST_OFF;
            end
            default: state_next = ST_LOCK;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!pin_rst_n) begin
            state_reg <= ST_LOCK;
            init_cnt_reg <= '0;
            step_cnt_reg <= '0;
            active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            init_cnt_reg <= init_cnt_next;
            step_cnt_reg <= step_cnt_next;
            active_reg <= active_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic busy;
    assign busy = state_reg inside {ST_LOCK, ST_CFG, ST_WAIT};
    assign link.init_busy_pin = active_reg & busy;
    assign link.init_busy_oe = 1'b1;
    assign link.mirror_array_power_enable =
        state_reg inside {ST_WAIT, ST_RUN, ST_PARK};
    assign link.mirror_array_power_enable_oe = active_reg;
    assign cfg_loaded = state_reg inside {ST_WAIT, ST_RUN, ST_PARK};
    assign ready_for_commands = state_reg == ST_RUN;
    assign parked = state_reg == ST_OFF;
    assign led_driver_on = state_reg == ST_RUN;
    assign led_driver_on_oe = active_reg;
    assign led_select = LED_SEL_RESET[1:0];
    assign led_select_oe = {2{active_reg}};
    assign flash_serial_clock = (state_reg == ST_CFG) & step_cnt_reg[0];
    assign flash_serial_out = (state_reg == ST_CFG) & flash_serial_in;
    assign flash_chip_select_n = state_reg != ST_CFG;
    assign flash_io_oe = active_reg;
endmodule : crps_ctrl
`default_nettype wire

/* crps_host.sv */
// Purpose: host and power monitor end of the reset and park handshake
// Assumes: power_ok and clock_stable come from board monitors
// Notes: busy pin from the controller is synchronised
`timescale 1ns/100ps
`default_nettype none
module crps_host import crps_pkg::*; #(
    parameter int PARK_DELAY = PARK_HIGH_CYC,
    parameter int HOST_TIMER = HOST_TIMER_CYC,
    parameter int PARK_WAIT = PARK_WAIT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    crps_if.host link,
    input wire logic power_ok,
    input wire logic clock_stable,
    input wire logic shutdown_req,
    output logic commands_allowed,
    output logic supplies_off_ok
);
    initial begin
        if (PARK_DELAY < 1 || PARK_DELAY > PARK_MAX_CYC)
            $error("park delay outside 1..limit");
        if (PARK_WAIT < 1)
            $error("park wait must be positive");
    end

    typedef enum logic [5:0] {
        H_HOLD = 6'h01, H_PARKUP = 6'h02, H_INIT = 6'h04,
        H_RUN = 6'h08, H_PARKDN = 6'h10, H_DOWN = 6'h20
    } crps_hstate_t;
    localparam int CW = $clog2(HOST_TIMER + PARK_WAIT + 1);
    crps_hstate_t st_reg, st_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [1:0] busy_sync_reg, busy_sync_next;
    logic [1:0] pwr_sync_reg, pwr_sync_next;
    always_comb begin
        busy_sync_next = {busy_sync_reg[0], link.init_busy_pin};
        pwr_sync_next = {pwr_sync_reg[0], link.mirror_array_power_enable};
        st_next = st_reg;
        cnt_next = cnt_reg + CW'(1);
        unique case (st_reg)
            H_HOLD: begin
                cnt_next = '0;
                if (power_ok && clock_stable) st_next = H_PARKUP;
            end
            H_PARKUP: if (cnt_reg == CW'(PARK_DELAY - 1)) st_next = H_INIT;
            H_INIT: begin
                if (!busy_sync_reg[1] || cnt_reg == CW'(HOST_TIMER))
                    st_next = H_RUN;
            end
            H_RUN: begin
                cnt_next = '0;
                if (shutdown_req) st_next = H_PARKDN;
            end
            H_PARKDN: if (cnt_reg == CW'(PARK_WAIT - 1)) st_next = H_DOWN;
            H_DOWN: cnt_next = cnt_reg;
            default: st_next = H_HOLD;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_reg <= H_HOLD;
            cnt_reg <= '0;
            busy_sync_reg <= 2'h0;
            pwr_sync_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            busy_sync_reg <= busy_sync_next;
            pwr_sync_reg <= pwr_sync_next;
        end
    end
    assign link.resetn_pin = !(st_reg inside {H_HOLD, H_DOWN});
    assign link.park_pin = st_reg inside {H_INIT, H_RUN};
    assign commands_allowed = st_reg == H_RUN;
    assign supplies_off_ok = st_reg == H_DOWN && !pwr_sync_reg[1];
endmodule : crps_host
`default_nettype wire

/* crps_asserts.sv */
// Purpose: checks on the pins between the two handshake ends
// Assumes: one clock, bench reset active low
// Notes: counts follow the shortened parameters of the ends
`timescale 1ns/100ps
`default_nettype none
module crps_asserts #(
    parameter int INIT_CYC = 400,
    parameter int PARK_CYC = 20,
    parameter int CFG_CYCLES = 16,
    parameter int PARK_DELAY = 5,
    parameter int PARK_WAIT = 50
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic resetn_pin,
    input wire logic park_pin,
    input wire logic init_busy_pin,
    input wire logic init_busy_oe,
    input wire logic mirror_array_power_enable,
    input wire logic mirror_array_power_enable_oe
);
    localparam int PARK_LIM = PARK_CYC + 16;
    localparam int PARK_HI = PARK_DELAY + 3;
    logic [31:0] busy_cnt_reg, busy_cnt_next, wait_cnt_reg, wait_cnt_next;
    // ----
    // cycle counters
    // ----
    always_comb begin
        busy_cnt_next = init_busy_pin ? busy_cnt_reg + 32'h1 : 32'h0;
        wait_cnt_next = (park_pin || !resetn_pin) ? 32'h0 : wait_cnt_reg + 32'h1;
    end
    always_ff @(posedge clk_sys) begin
        busy_cnt_reg <= resetn ? busy_cnt_next : 32'h0;
        wait_cnt_reg <= resetn ? wait_cnt_next : 32'h0;
    end
    // ----
    // properties
    // ----
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence in_reset_s;
        !resetn_pin [*4];
    endsequence
    sequence park_drop_s;
        $fell(park_pin) && !init_busy_pin && mirror_array_power_enable;
    endsequence
    reset_outputs_a: assert property (in_reset_s |->
        !init_busy_pin && !mirror_array_power_enable) else $error("outputs on");
    reset_hiz_a: assert property (in_reset_s |->
        !mirror_array_power_enable_oe) else $error("enable driven");
    busy_release_a: assert property ($rose(resetn_pin) |->
        ##[1:4] init_busy_pin && init_busy_oe) else $error("busy late");
    busy_min_a: assert property ($fell(init_busy_pin) |->
        busy_cnt_reg >= INIT_CYC - 3) else $error("busy short");
    power_order_a: assert property ($rose(mirror_array_power_enable) |->
        init_busy_pin && busy_cnt_reg >= CFG_CYCLES) else $error("early power");
    park_done_a: assert property (park_drop_s |->
        ##[1:PARK_LIM] !mirror_array_power_enable) else $error("park slow");
    park_rise_a: assert property ($rose(resetn_pin) |->
        ##[1:PARK_HI] park_pin) else $error("park late");
    reset_wait_a: assert property ($fell(resetn_pin) |->
        wait_cnt_reg >= PARK_WAIT - 1) else $error("reset early");
endmodule : crps_asserts
`default_nettype wire

/* crps_test.sv */
// Purpose: bench for both ends of the reset and park handshake
// Assumes: counts shortened by parameters
// Notes: second controller takes park glitches from the bench
`timescale 1ns/100ps
`default_nettype none
module crps_test import crps_pkg::*; ;
    localparam int INIT = 400;
    localparam int PCYC = 20;
    localparam int CFG = 16;
    localparam int PWAIT = 50;
    logic clk_sys = 1'b0, resetn = 1'b0, power_ok = 1'b0;
    logic clock_stable = 1'b0, shutdown_req = 1'b0, pll_locked = 1'b0;
    logic flash_serial_in = 1'b0, cfg_loaded, ready_for_commands, parked2;
    logic led_driver_on_oe, flash_io_oe, commands_allowed, supplies_off_ok;
    logic [1:0] led_select_oe;
    logic led_on, flash_cs_n;
    logic [31:0] seed = 32'hA2F3;
    int errors = 0, comparisons = 0, n, len;
    crps_if l1();
    crps_if l2();
    always #12.5 clk_sys = ~clk_sys;
    crps_ctrl #(.INIT_CYC(INIT), .PARK_CYC(PCYC), .LOCK_CYCLES(8),
        .CFG_CYCLES(CFG)) i_crps_ctrl (.clk_sys(clk_sys), .resetn(resetn),
        .link(l1.ctrl), .pll_locked(pll_locked), .flash_serial_in(flash_serial_in),
        .cfg_loaded(cfg_loaded), .ready_for_commands(ready_for_commands),
        .parked(), .led_driver_on(led_on), .led_driver_on_oe(led_driver_on_oe),
        .led_select(), .led_select_oe(led_select_oe), .flash_serial_clock(),
        .flash_serial_out(), .flash_chip_select_n(flash_cs_n),
        .flash_io_oe(flash_io_oe));
    crps_ctrl #(.INIT_CYC(INIT), .PARK_CYC(PCYC), .LOCK_CYCLES(8),
        .CFG_CYCLES(CFG)) i_crps_ctrl2 (.clk_sys(clk_sys), .resetn(resetn),
        .link(l2.ctrl), .pll_locked(pll_locked), .flash_serial_in(flash_serial_in),
        .cfg_loaded(), .ready_for_commands(), .parked(parked2),
        .led_driver_on(), .led_driver_on_oe(), .led_select(), .led_select_oe(),
        .flash_serial_clock(), .flash_serial_out(), .flash_chip_select_n(),
        .flash_io_oe());
    crps_host #(.PARK_DELAY(5), .HOST_TIMER(500), .PARK_WAIT(PWAIT)) i_crps_host (
        .clk_sys(clk_sys), .resetn(resetn), .link(l1.host), .power_ok(power_ok),
        .clock_stable(clock_stable), .shutdown_req(shutdown_req),
        .commands_allowed(commands_allowed), .supplies_off_ok(supplies_off_ok));
    crps_asserts #(.INIT_CYC(INIT), .PARK_CYC(PCYC), .CFG_CYCLES(CFG),
        .PARK_DELAY(5), .PARK_WAIT(PWAIT)) i_crps_asserts (.clk_sys(clk_sys),
        .resetn(resetn), .resetn_pin(l1.resetn_pin), .park_pin(l1.park_pin),
        .init_busy_pin(l1.init_busy_pin), .init_busy_oe(l1.init_busy_oe),
        .mirror_array_power_enable(l1.mirror_array_power_enable),
        .mirror_array_power_enable_oe(l1.mirror_array_power_enable_oe));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic glitch_kept(input int cycles);
        return cycles * CLK_PERIOD_PS > GLITCH_NS * 1000;
    endfunction : glitch_kept
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
        seed = lfsr(seed);
        flash_serial_in <= seed[0];
    endtask : tick
    task automatic check(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check
    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // ----
    // tests
    // ----
    initial begin
        l2.resetn_pin = 1'b0;
        l2.park_pin = 1'b0;
        tick(2);
        resetn <= 1'b1;
        power_ok <= 1'b1;
        tick(20);
        check(l1.resetn_pin, 1'b0, "reset early");
        check(l1.init_busy_pin, 1'b0, "busy in reset");
        check(led_driver_on_oe | (|led_select_oe) | flash_io_oe, 1'b0, "hiz");
        $display("test hold done");
        clock_stable <= 1'b1;
        l2.resetn_pin <= 1'b1;
        l2.park_pin <= 1'b1;
        for (n = 0; n < 10 && l1.init_busy_pin !== 1'b1; n++) tick(1);
        check(l1.init_busy_pin, 1'b1, "busy late");
        check(flash_io_oe, 1'b1, "pins idle");
        tick(INIT + 20);
        check(l1.init_busy_pin, 1'b1, "busy ended");
        check(cfg_loaded, 1'b0, "load before lock");
        check(commands_allowed, 1'b0, "commands early");
        tick(100);
        check(commands_allowed, 1'b1, "host timer");
        pll_locked <= 1'b1;
        for (n = 0; n < 1000 && l1.init_busy_pin !== 1'b0; n++) tick(1);
        check(cfg_loaded & ready_for_commands, 1'b1, "init end");
        check(led_on & flash_cs_n, 1'b1, "pins active");
        $display("test init done");
        tick(5);
        for (n = 0; n < 6; n++) begin
            len = (n == 0) ? 6 : int'(seed % 32'h6) + 1;
            l2.park_pin <= 1'b0;
            tick(len);
            l2.park_pin <= 1'b1;
            tick(PCYC + 16);
            check(parked2, glitch_kept(len), "glitch");
        end
        l2.park_pin <= 1'b0;
        for (n = 0; n < PCYC + 16 && parked2 !== 1'b1; n++) tick(1);
        check(parked2, 1'b1, "park slow");
        $display("test glitch done");
        shutdown_req <= 1'b1;
        for (n = 0; n < 20 && l1.park_pin !== 1'b0; n++) tick(1);
        for (n = 0; n < PWAIT + 20 && l1.resetn_pin !== 1'b0; n++) tick(1);
        check(n >= PWAIT - 1 && l1.resetn_pin === 1'b0, 1'b1, "wait");
        check(l1.mirror_array_power_enable, 1'b0, "not parked");
        for (n = 0; n < 200 && supplies_off_ok !== 1'b1; n++) tick(1);
        check(supplies_off_ok, 1'b1, "supply order");
        tick(4);
        check(l1.init_busy_pin | l1.mirror_array_power_enable, 1'b0, "out");
        check(l1.mirror_array_power_enable_oe | flash_io_oe, 1'b0, "hiz");
        $display("test shutdown done");
        stop_test();
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        errors++;
        $display("wrong value at %0t: run hung", $time);
        stop_test();
    end
endmodule : crps_test
`default_nettype wire
